// ==== rtl/pfs_pin_mux.sv ====
`timescale 1ns/1ps
module pfs_pin_mux
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_reset_pin_b,
  input wire logic i_int_reset_req,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe,
  input wire logic i_debug_comm_pin,
  input wire logic [31:0] i_pin_in,
  output logic [31:0] o_pin_out,
  output logic [31:0] o_pin_oe,
  output logic o_clock_source_strap_pd,
  input wire logic [31:0] i_alt_out,
  input wire logic [31:0] i_alt_oe,
  input wire pfs_pkg::pfs_bus_req_t i_bus,
  input wire logic i_bus_clk,
  input wire logic i_bus_clk_fall,
  input wire logic [1:0] i_queue_state,
  output logic [15:0] o_ext_rdata,
  output logic o_high_half_tag,
  output logic o_low_half_tag,
  output logic o_expanded,
  output pfs_pkg::pfs_mode_t o_mode,
  output logic o_clk_ext_clock,
  output logic o_use_pll,
  output logic o_flash_map_enable,
  input wire logic i_spi_en,
  input wire logic i_spi_master,
  input wire logic i_spi_mosi_out,
  input wire logic i_spi_miso_out,
  input wire logic i_mosi_pin,
  input wire logic i_miso_pin,
  output logic o_mosi_pin_out,
  output logic o_mosi_pin_oe,
  output logic o_miso_pin_out,
  output logic o_miso_pin_oe,
  output logic o_spi_data_in,
  input wire logic [11:0] i_wake_pins,
  input wire logic i_low_power,
  output logic o_irq_req,
  output logic o_nmi_req,
  output logic o_key_wake_irq,
  output logic o_wake_req,
  input wire logic [15:0] i_cpu_addr,
  output logic o_reg_space_hit
);
  import pfs_pkg::*;

  logic [31:0] pin_s1_reg, pin_s2_reg;
  logic rst_s1_reg, rst_s2_reg, rst_d_reg;
  logic dbg_s1_reg, dbg_s2_reg;
  logic [11:0] wake_s1_reg, wake_s2_reg, wake_d_reg;
  logic mosi_s1_reg, mosi_s2_reg, miso_s1_reg, miso_s2_reg;
  logic [31:0] gpio_data_reg, gpio_dir_reg, alt_en_reg, ctrl_reg;
  logic [11:0] wake_en_reg, wake_flag_reg;
  pfs_mode_t mode_reg;
  logic clk_ext_reg, flash_map_reg;
  logic rst_active, rst_rise, expanded, tag_on;
  logic [31:0] bus_en, bus_out, bus_oe, pin_out_next, pin_oe_next;
  logic [11:0] wake_set, wake_clr;
  logic [31:0] rdata_next;

  // two-stage synchronisers for every pin input
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      // idle high, so the active-low request pins do not fire at reset exit
      pin_s1_reg <= 32'hFFFF_FFFF;
      pin_s2_reg <= 32'hFFFF_FFFF;
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      rst_d_reg <= 1'b0;
      dbg_s1_reg <= 1'b1;
      dbg_s2_reg <= 1'b1;
      wake_s1_reg <= 12'hFFF;
      wake_s2_reg <= 12'hFFF;
      wake_d_reg <= 12'hFFF;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= i_pin_in;
      pin_s2_reg <= pin_s1_reg;
      rst_s1_reg <= i_reset_pin_b;
      rst_s2_reg <= rst_s1_reg;
      rst_d_reg <= rst_s2_reg;
      dbg_s1_reg <= i_debug_comm_pin;
      dbg_s2_reg <= dbg_s1_reg;
      wake_s1_reg <= i_wake_pins;
      wake_s2_reg <= wake_s1_reg;
      wake_d_reg <= wake_s2_reg;
      mosi_s1_reg <= i_mosi_pin;
      mosi_s2_reg <= mosi_s1_reg;
      miso_s1_reg <= i_miso_pin;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  assign rst_active = !rst_s2_reg;
  assign rst_rise = rst_s2_reg && !rst_d_reg;
  assign expanded = (mode_reg.mode_strap_a || mode_reg.mode_strap_b) && !rst_active;
  assign tag_on = expanded && ctrl_reg[CTRL_TAG_EN];

  // device drives its own reset pin low on an internal reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_reset_pin_out <= 1'b0;
      o_reset_pin_oe <= 1'b0;
    end
    else
    begin
      o_reset_pin_out <= 1'b0;
      o_reset_pin_oe <= i_int_reset_req;
    end
  end

  // strap capture at the release of the reset pin
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_reg <= MODE_RESET;
      clk_ext_reg <= 1'b0;
      flash_map_reg <= 1'b0;
    end
    else if (rst_rise)
    begin
      mode_reg.mode_select_bit_c <= dbg_s2_reg;
      mode_reg.mode_strap_a <= pin_s2_reg[PIN_MODE_STRAP_A];
      mode_reg.mode_strap_b <= pin_s2_reg[PIN_MODE_STRAP_B];
      clk_ext_reg <= pin_s2_reg[PIN_CLOCK_SOURCE_STRAP];
      flash_map_reg <= pin_s2_reg[PIN_ECS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_clock_source_strap_pd <= 1'b1;
    else
      o_clock_source_strap_pd <= rst_active;
  end

  // software registers; reset pin returns control to defaults
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      gpio_data_reg <= 32'h0000_0000;
      gpio_dir_reg <= 32'h0000_0000;
      alt_en_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
      wake_en_reg <= WAKE_RESET;
    end
    else if (rst_active)
    begin
      gpio_dir_reg <= 32'h0000_0000;
      alt_en_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
      wake_en_reg <= WAKE_RESET;
    end
    else if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        REG_GPIO_DATA: gpio_data_reg <= i_reg_wdata;
        REG_GPIO_DIR: gpio_dir_reg <= i_reg_wdata;
        REG_ALT_EN: alt_en_reg <= i_reg_wdata;
        REG_CTRL: ctrl_reg <= i_reg_wdata & CTRL_WMASK;
        REG_WAKE_EN: wake_en_reg <= i_reg_wdata[NWAKE-1:0];
        default: ;
      endcase
    end
  end

  // key wake-up flags, set on a falling edge, write one to clear; set wins
  assign wake_set = wake_d_reg & ~wake_s2_reg & wake_en_reg;
  assign wake_clr = (i_reg_wr && i_reg_addr == REG_WAKE_FLAG) ? i_reg_wdata[NWAKE-1:0] : 12'h000;

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      wake_flag_reg <= 12'h000;
    else
      wake_flag_reg <= (wake_flag_reg & ~wake_clr) | wake_set;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_irq_req <= 1'b0;
      o_nmi_req <= 1'b0;
      o_key_wake_irq <= 1'b0;
      o_wake_req <= 1'b0;
    end
    else
    begin
      o_irq_req <= !pin_s2_reg[PIN_IRQ];
      o_nmi_req <= !pin_s2_reg[PIN_NMI];
      o_key_wake_irq <= |wake_flag_reg;
      o_wake_req <= i_low_power && (!pin_s2_reg[PIN_IRQ] || !pin_s2_reg[PIN_NMI] || |wake_flag_reg);
    end
  end

  // expanded-bus and special functions overriding the pins
  always_comb
  begin
    bus_en = 32'h0000_0000;
    bus_out = 32'h0000_0000;
    bus_oe = 32'h0000_0000;
    if (rst_active)
    begin
      bus_en[PIN_MODE_STRAP_A] = 1'b1;
      bus_en[PIN_MODE_STRAP_B] = 1'b1;
      bus_en[PIN_CLOCK_SOURCE_STRAP] = 1'b1;
      bus_en[PIN_ECS] = 1'b1;
    end
    else
    begin
      if (ctrl_reg[CTRL_BUS_CLOCK_OUT_EN])
      begin
        bus_en[PIN_BUS_CLOCK_OUT] = 1'b1;
        bus_out[PIN_BUS_CLOCK_OUT] = i_bus_clk;
        bus_oe[PIN_BUS_CLOCK_OUT] = 1'b1;
      end
      if (expanded)
      begin
        bus_en[PB_LSB +: 8] = 8'hFF;
        bus_en[PA_LSB +: 8] = 8'hFF;
        bus_out[PB_LSB +: 8] = i_bus.addr_phase ? i_bus.addr[7:0] : i_bus.wdata[7:0];
        bus_out[PA_LSB +: 8] = i_bus.addr_phase ? i_bus.addr[15:8] : i_bus.wdata[15:8];
        bus_oe[PB_LSB +: 8] = {8{i_bus.addr_phase || i_bus.data_drive}};
        bus_oe[PA_LSB +: 8] = {8{i_bus.addr_phase || i_bus.data_drive}};
        bus_en[PK_LSB +: 4] = 4'hF;
        bus_out[PK_LSB +: 4] = i_bus.addr[XADDR_LSB +: 4];
        bus_oe[PK_LSB +: 4] = 4'hF;
        bus_en[PIN_RW] = 1'b1;
        bus_out[PIN_RW] = i_bus.rd_nwr;
        bus_oe[PIN_RW] = 1'b1;
        bus_en[PIN_LOW_BYTE_STROBE] = 1'b1;
        bus_out[PIN_LOW_BYTE_STROBE] = i_bus.low_byte_strobe_b;
        bus_oe[PIN_LOW_BYTE_STROBE] = !tag_on;
        bus_en[PIN_ECS] = 1'b1;
        bus_out[PIN_ECS] = i_bus.emulation_chip_select_b;
        bus_oe[PIN_ECS] = ctrl_reg[CTRL_ECS_EN];
        if (ctrl_reg[CTRL_FREE_EN])
        begin
          bus_en[PIN_CLOCK_SOURCE_STRAP] = 1'b1;
          bus_out[PIN_CLOCK_SOURCE_STRAP] = i_bus.idle;
          bus_oe[PIN_CLOCK_SOURCE_STRAP] = 1'b1;
        end
        if (ctrl_reg[CTRL_PIPE_EN])
        begin
          bus_en[PIN_MODE_STRAP_A] = 1'b1;
          bus_en[PIN_MODE_STRAP_B] = 1'b1;
          bus_out[PIN_MODE_STRAP_A] = i_queue_state[0];
          bus_out[PIN_MODE_STRAP_B] = i_queue_state[1];
          bus_oe[PIN_MODE_STRAP_A] = 1'b1;
          bus_oe[PIN_MODE_STRAP_B] = 1'b1;
        end
      end
    end
  end

  // per-pin priority: bus function, then peripheral, then gpio
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      assign pin_out_next[g] = bus_en[g] ? bus_out[g] : (alt_en_reg[g] ? i_alt_out[g] : gpio_data_reg[g]);
      assign pin_oe_next[g] = bus_en[g] ? bus_oe[g] : (alt_en_reg[g] ? i_alt_oe[g] : gpio_dir_reg[g]);
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pin_out <= 32'h0000_0000;
      o_pin_oe <= 32'h0000_0000;
    end
    else
    begin
      o_pin_out <= pin_out_next;
      o_pin_oe <= pin_oe_next;
    end
  end

  // tagging, read data and mode outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_high_half_tag <= 1'b0;
      o_low_half_tag <= 1'b0;
      o_ext_rdata <= 16'h0000;
      o_expanded <= 1'b0;
      o_mode <= MODE_RESET;
      o_clk_ext_clock <= 1'b0;
      o_use_pll <= 1'b0;
      o_flash_map_enable <= 1'b0;
      o_reg_space_hit <= 1'b0;
    end
    else
    begin
      o_high_half_tag <= tag_on && i_bus_clk_fall && !dbg_s2_reg;
      o_low_half_tag <= tag_on && i_bus_clk_fall && !pin_s2_reg[PIN_LOW_BYTE_STROBE];
      o_ext_rdata <= {pin_s2_reg[PA_LSB +: 8], pin_s2_reg[PB_LSB +: 8]};
      o_expanded <= expanded;
      o_mode <= mode_reg;
      o_clk_ext_clock <= clk_ext_reg;
      o_use_pll <= ctrl_reg[CTRL_PLL_SEL] && !rst_active;
      o_flash_map_enable <= flash_map_reg;
      o_reg_space_hit <= i_cpu_addr[15:10] == ctrl_reg[CTRL_BASE_LSB +: CTRL_BASE_W];
    end
  end

  // spi data pins turn around with the role
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_mosi_pin_out <= 1'b0;
      o_mosi_pin_oe <= 1'b0;
      o_miso_pin_out <= 1'b0;
      o_miso_pin_oe <= 1'b0;
      o_spi_data_in <= 1'b0;
    end
    else
    begin
      o_mosi_pin_out <= i_spi_mosi_out;
      o_mosi_pin_oe <= i_spi_en && i_spi_master;
      o_miso_pin_out <= i_spi_miso_out;
      o_miso_pin_oe <= i_spi_en && !i_spi_master;
      o_spi_data_in <= i_spi_master ? miso_s2_reg : mosi_s2_reg;
    end
  end

  // register read port, data one cycle after the strobe
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (i_reg_addr)
      REG_GPIO_DATA: rdata_next = gpio_data_reg;
      REG_GPIO_DIR: rdata_next = gpio_dir_reg;
      REG_ALT_EN: rdata_next = alt_en_reg;
      REG_CTRL: rdata_next = ctrl_reg;
      REG_STATUS:
      begin
        rdata_next[STAT_MODE_A] = mode_reg.mode_strap_a;
        rdata_next[STAT_MODE_B] = mode_reg.mode_strap_b;
        rdata_next[STAT_MODE_C] = mode_reg.mode_select_bit_c;
        rdata_next[STAT_CLK_EXT] = clk_ext_reg;
        rdata_next[STAT_FLASH_MAP] = flash_map_reg;
        rdata_next[STAT_EXPANDED] = expanded;
        rdata_next[STAT_RST_ACTIVE] = rst_active;
      end
      REG_PIN_IN: rdata_next = pin_s2_reg;
      REG_WAKE_EN: rdata_next[NWAKE-1:0] = wake_en_reg;
      REG_WAKE_FLAG: rdata_next[NWAKE-1:0] = wake_flag_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_reg_rdata <= 32'h0000_0000;
    else if (i_reg_rd)
      o_reg_rdata <= rdata_next;
    else
      o_reg_rdata <= 32'h0000_0000;
  end

  // checks
  property p_mode_c_capture;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    rst_rise |=> (mode_reg.mode_select_bit_c == $past(dbg_s2_reg));
  endproperty
  a_mode_c_capture: assert property (p_mode_c_capture) else $error("mode bit c not captured");

  property p_mode_ab_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !rst_rise |=> $stable(mode_reg);
  endproperty
  a_mode_ab_hold: assert property (p_mode_ab_hold) else $error("mode changed outside reset release");

  property p_pulldown;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    rst_active |=> o_clock_source_strap_pd && !o_pin_oe[PIN_CLOCK_SOURCE_STRAP];
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("clock strap not released with pull-down");

  property p_no_pll_after_reset;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    rst_rise |=> !o_use_pll [*2];
  endproperty
  a_no_pll_after_reset: assert property (p_no_pll_after_reset) else $error("pll selected at reset exit");

  property p_free_cycle;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (expanded && ctrl_reg[CTRL_FREE_EN] && i_bus.idle) |=> o_pin_out[PIN_CLOCK_SOURCE_STRAP] && o_pin_oe[PIN_CLOCK_SOURCE_STRAP];
  endproperty
  a_free_cycle: assert property (p_free_cycle) else $error("free cycle not shown");

  property p_high_tag;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    o_high_half_tag |-> $past(tag_on) && $past(i_bus_clk_fall) && !$past(dbg_s2_reg);
  endproperty
  a_high_tag: assert property (p_high_tag) else $error("stray high tag");

  property p_reset_drive;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    i_int_reset_req |=> o_reset_pin_oe && !o_reset_pin_out;
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("reset pin not driven low");

  property p_nmi_wake;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_low_power && !pin_s2_reg[PIN_NMI]) |=> o_wake_req;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("nonmaskable request did not wake");

  property p_wake_set_wins;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (wake_set != 12'h000) |=> ((wake_flag_reg & $past(wake_set)) == $past(wake_set));
  endproperty
  a_wake_set_wins: assert property (p_wake_set_wins) else $error("wake event lost");

  property p_spi_dir;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    i_spi_en |=> (o_mosi_pin_oe != o_miso_pin_oe);
  endproperty
  a_spi_dir: assert property (p_spi_dir) else $error("spi pins not opposed");

  property p_addr_phase;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (expanded && i_bus.addr_phase) |=> o_pin_out[PB_LSB +: 8] == $past(i_bus.addr[7:0]);
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("low address byte wrong");

  c_reset_release: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) rst_rise);
  c_expanded_cycle: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) expanded && i_bus.addr_phase);
  c_key_wake: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) i_low_power && |wake_set);
  c_tag: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_high_half_tag);

endmodule

// ==== common/pfs_pkg.sv ====
package pfs_pkg;

  // register indices on the plain register port
  localparam logic [3:0] REG_GPIO_DATA = 4'h0;
  localparam logic [3:0] REG_GPIO_DIR = 4'h1;
  localparam logic [3:0] REG_ALT_EN = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PIN_IN = 4'h5;
  localparam logic [3:0] REG_WAKE_EN = 4'h6;
  localparam logic [3:0] REG_WAKE_FLAG = 4'h7;

  // control register fields
  localparam int CTRL_PLL_SEL = 0;
  localparam int CTRL_FREE_EN = 1;
  localparam int CTRL_TAG_EN = 2;
  localparam int CTRL_BUS_CLOCK_OUT_EN = 3;
  localparam int CTRL_PIPE_EN = 4;
  localparam int CTRL_ECS_EN = 5;
  localparam int CTRL_BASE_LSB = 8;
  localparam int CTRL_BASE_W = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_3F3F;

  // status register fields
  localparam int STAT_MODE_A = 0;
  localparam int STAT_MODE_B = 1;
  localparam int STAT_MODE_C = 2;
  localparam int STAT_CLK_EXT = 3;
  localparam int STAT_FLASH_MAP = 4;
  localparam int STAT_EXPANDED = 5;
  localparam int STAT_RST_ACTIVE = 6;

  // pin vector layout: port A, B, K, E
  localparam int NPINS = 32;
  localparam int PA_LSB = 0;
  localparam int PB_LSB = 8;
  localparam int PK_LSB = 16;
  localparam int PE_LSB = 24;
  localparam int XADDR_LSB = 14;
  localparam int PIN_ECS = 23;
  localparam int PIN_NMI = 24;
  localparam int PIN_IRQ = 25;
  localparam int PIN_RW = 26;
  localparam int PIN_LOW_BYTE_STROBE = 27;
  localparam int PIN_BUS_CLOCK_OUT = 28;
  localparam int PIN_MODE_STRAP_A = 29;
  localparam int PIN_MODE_STRAP_B = 30;
  localparam int PIN_CLOCK_SOURCE_STRAP = 31;

  localparam int NWAKE = 12;
  localparam logic [11:0] WAKE_RESET = 12'h000;

  // captured operating mode
  typedef struct packed {
    logic mode_select_bit_c;
    logic mode_strap_b;
    logic mode_strap_a;
  } pfs_mode_t;
  localparam pfs_mode_t MODE_RESET = 3'h0;

  // request from the core's external bus engine
  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] wdata;
    logic addr_phase;
    logic data_drive;
    logic rd_nwr;
    logic low_byte_strobe_b;
    logic emulation_chip_select_b;
    logic idle;
  } pfs_bus_req_t;

endpackage

// ==== testbench/pfs_board_model.sv ====
`timescale 1ns/1ps
module pfs_board_model
(
  input wire logic [31:0] i_pin_out,
  input wire logic [31:0] i_pin_oe,
  input wire logic i_strap_pd,
  input wire logic i_rst_oe,
  input wire logic i_hold_rst,
  input wire logic [31:0] i_drive,
  input wire logic [31:0] i_drive_en,
  output logic [31:0] o_level,
  output logic o_reset_b
);
  import pfs_pkg::*;
  // device drive wins, then board straps, else pull level
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      if (i_pin_oe[i])
        o_level[i] = i_pin_out[i];
      else if (i_drive_en[i])
        o_level[i] = i_drive[i];
      else
        o_level[i] = !(i == PIN_CLOCK_SOURCE_STRAP && i_strap_pd);
    end
  end
  // open-drain reset line, low from board or device
  assign o_reset_b = !(i_hold_rst || i_rst_oe);
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
`define WAIT(c) \
  begin \
    for (int n = 0; !(c); n++) \
    begin \
      if (n == 40) \
      begin \
        bad_count++; \
        $display("CHECK FAILED t=%0t timeout", $time); \
        give_verdict(); \
      end \
      @(posedge clk); \
      #1; \
    end \
  end
module tb_top;
  import pfs_pkg::*;
  logic clk, rst_b, wr, rd, dbg, bclk, bfall, int_rst, hold_rst, spi_en, spi_m, mosi_o;
  logic rst_pin, pd, rst_oe, hi_tag, lo_tag, expd, use_pll, clk_ext, fmap, irq, nmi, kwake, wreq, hit;
  logic mosi_out, mosi_oe, miso_oe;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, drv, drv_en, alt_out, alt_oe, lvl, pout, poe;
  logic [11:0] wake;
  logic [15:0] cpu_addr, ext_rd;
  logic [1:0] qs;
  logic rst_out, spi_in, miso_out, lowp;
  pfs_bus_req_t bus;
  pfs_mode_t mode;
  int bad_count, tests_run;

  pfs_pin_mux u_pfs_pin_mux (.i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_reset_pin_b(rst_pin), .i_int_reset_req(int_rst),
    .o_reset_pin_out(rst_out), .o_reset_pin_oe(rst_oe), .i_debug_comm_pin(dbg), .i_pin_in(lvl), .o_pin_out(pout),
    .o_pin_oe(poe), .o_clock_source_strap_pd(pd), .i_alt_out(alt_out), .i_alt_oe(alt_oe), .i_bus(bus),
    .i_bus_clk(bclk), .i_bus_clk_fall(bfall), .i_queue_state(qs), .o_ext_rdata(ext_rd), .o_high_half_tag(hi_tag),
    .o_low_half_tag(lo_tag), .o_expanded(expd), .o_mode(mode), .o_clk_ext_clock(clk_ext), .o_use_pll(use_pll),
    .o_flash_map_enable(fmap), .i_spi_en(spi_en), .i_spi_master(spi_m), .i_spi_mosi_out(mosi_o),
    .i_spi_miso_out(mosi_o), .i_mosi_pin(1'b0), .i_miso_pin(mosi_o), .o_mosi_pin_out(mosi_out),
    .o_mosi_pin_oe(mosi_oe), .o_miso_pin_out(miso_out), .o_miso_pin_oe(miso_oe), .o_spi_data_in(spi_in),
    .i_wake_pins(wake), .i_low_power(lowp), .o_irq_req(irq), .o_nmi_req(nmi), .o_key_wake_irq(kwake),
    .o_wake_req(wreq), .i_cpu_addr(cpu_addr), .o_reg_space_hit(hit));

  pfs_board_model u_pfs_board_model (.i_pin_out(pout), .i_pin_oe(poe), .i_strap_pd(pd), .i_rst_oe(rst_oe),
    .i_hold_rst(hold_rst), .i_drive(drv), .i_drive_en(drv_en), .o_level(lvl), .o_reset_b(rst_pin));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp);
    @(posedge clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial
  begin
    {rst_b, wr, rd, bfall, int_rst, spi_en, spi_m, mosi_o, lowp} = '0;
    qs = 2'h2;
    {addr, wdata, alt_out, cpu_addr} = '0;
    {dbg, bclk, hold_rst} = 3'h7;
    alt_oe = 32'hFFFF_FFFF;
    wake = 12'hFFF;
    drv = 32'hBFFF_FFFF;
    drv_en = 32'hFFFF_FFFF;
    bus = '0;
    cyc(2);
    `CHK(pd, 1'b1);
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(4);
    `CHK(expd, 1'b0);
    chk_reg(REG_STATUS, 32'h0000_0040);
    wr_reg(REG_CTRL, 32'h0000_003F);
    chk_reg(REG_CTRL, 32'h0000_0000);
    hold_rst <= 1'b0;
    cyc(6);
    `CHK(mode, pfs_mode_t'(3'h5));
    `CHK({clk_ext, use_pll, expd, fmap}, 4'hB);
    chk_reg(REG_STATUS, 32'h0000_003D);
    chk_reg(4'hF, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_002A);
    bus <= '{addr: 18'h2E5A7, wdata: 16'h1234, addr_phase: 1'b1, data_drive: 1'b0, rd_nwr: 1'b1,
      low_byte_strobe_b: 1'b0, emulation_chip_select_b: 1'b0, idle: 1'b1};
    cyc(2);
    `CHK(pout[19:0], 20'hBA7E5);
    `CHK(poe[15:0], 16'hFFFF);
    `CHK({pout[31], pout[28:26], poe[27], pout[23], poe[23]}, 7'h6D);
    @(posedge clk);
    bus <= '{addr: 18'h2E5A7, wdata: 16'h1234, addr_phase: 1'b0, data_drive: 1'b1, rd_nwr: 1'b0,
      low_byte_strobe_b: 1'b1, emulation_chip_select_b: 1'b1, idle: 1'b0};
    bclk <= 1'b0;
    cyc(2);
    `CHK(pout[15:0], 16'h3412);
    `CHK({pout[31], pout[28:26], pout[23]}, 5'h05);
    @(posedge clk);
    wr_reg(REG_GPIO_DIR, 32'h0010_0001);
    wr_reg(REG_GPIO_DATA, 32'h0010_0000);
    #1;
    `CHK(pout[20], 1'b1);
    `CHK(ext_rd, 16'h1234);
    wr_reg(REG_ALT_EN, 32'h0010_0002);
    #1;
    `CHK({pout[20], pout[1]}, 2'h1);
    wr_reg(REG_CTRL, 32'h0000_003E);
    dbg <= 1'b0;
    drv[27] <= 1'b0;
    cyc(4);
    `CHK({poe[27], pout[30:29]}, 3'h2);
    @(posedge clk);
    bfall <= 1'b1;
    @(posedge clk);
    bfall <= 1'b0;
    #1;
    `CHK({hi_tag, lo_tag}, 2'h3);
    cyc(1);
    `CHK({hi_tag, lo_tag}, 2'h0);
    dbg <= 1'b1;
    spi_en <= 1'b1;
    spi_m <= 1'b1;
    mosi_o <= 1'b1;
    cpu_addr <= 16'h03FF;
    cyc(3);
    `CHK({mosi_oe, mosi_out, miso_oe, hit, spi_in}, 5'h1B);
    spi_m <= 1'b0;
    cpu_addr <= 16'h0400;
    cyc(3);
    `CHK({mosi_oe, miso_oe, miso_out, hit, spi_in}, 5'h0C);
    drv[25] <= 1'b0;
    lowp <= 1'b1;
    `WAIT(irq && wreq);
    drv[25] <= 1'b1;
    drv[24] <= 1'b0;
    `WAIT(nmi && wreq);
    drv[24] <= 1'b1;
    @(posedge clk);
    wr_reg(REG_WAKE_EN, 32'h0000_0001);
    wake[0] <= 1'b0;
    `WAIT(kwake);
    chk_reg(REG_WAKE_FLAG, 32'h0000_0001);
    wr_reg(REG_WAKE_FLAG, 32'h0000_0001);
    #1;
    `CHK(kwake, 1'b0);
    wr_reg(REG_CTRL, 32'h0000_002F);
    #1;
    `CHK(use_pll, 1'b1);
    int_rst <= 1'b1;
    cyc(1);
    `CHK({rst_oe, rst_out}, 2'h2);
    cyc(4);
    `CHK({expd, use_pll}, 2'h0);
    int_rst <= 1'b0;
    rst_b <= 1'b0;
    hold_rst <= 1'b1;
    drv_en[31] <= 1'b0;
    cyc(2);
    `CHK(pd, 1'b1);
    rst_b <= 1'b1;
    hold_rst <= 1'b0;
    cyc(8);
    `CHK({clk_ext, use_pll}, 2'h0);
    give_verdict();
  end
endmodule
